// ===== logic/cdt_pkg.sv
// Shared constants and types of the operand decoder and transfer engine.
// Assumes a single 200 MHz clock and an Avalon-MM register slave.
package cdt_pkg;
	// Bus, pin and divider widths
	localparam int CDT_AW     = 8;
	localparam int CDT_DW     = 32;
	localparam int CDT_PORT_W = 8;
	localparam int CDT_DIV_W  = 3;

	// Register byte offsets
	localparam logic [7:0] CDT_OFF_CMD  = 8'h00;
	localparam logic [7:0] CDT_OFF_STAT = 8'h04;
	localparam logic [7:0] CDT_OFF_PSW  = 8'h08;
	localparam logic [7:0] CDT_OFF_PCC  = 8'h0C;
	localparam logic [7:0] CDT_OFF_PC   = 8'h10;
	localparam logic [7:0] CDT_OFF_RLO  = 8'h14;
	localparam logic [7:0] CDT_OFF_RHI  = 8'h18;
	localparam logic [7:0] CDT_OFF_ADDR = 8'h1C;
	localparam logic [7:0] CDT_OFF_PORT = 8'h20;
	localparam logic [7:0] CDT_OFF_SAVE = 8'h24;

	// Command word field positions
	localparam int CDT_CMD_OP  = 0;
	localparam int CDT_CMD_R   = 4;
	localparam int CDT_CMD_RP  = 8;
	localparam int CDT_CMD_IMM = 16;

	// Status bit positions
	localparam int CDT_ST_BUSY = 0;
	localparam int CDT_ST_EOP  = 1;
	localparam int CDT_ST_EAD  = 2;
	localparam int CDT_ST_PROG = 3;

	// Program status word layout
	localparam int CDT_PSW_CY   = 0;
	localparam int CDT_PSW_NMI_IN_PROGRESS_FLAG = 1;
	localparam int CDT_PSW_AC   = 4;
	localparam int CDT_PSW_Z    = 6;
	localparam int CDT_PSW_IE   = 7;
	localparam logic [7:0] CDT_PSW_MASK = 8'hD3;

	// General register numbers and the word accumulator pair
	localparam logic [2:0] CDT_R_X = 3'h0;
	localparam logic [2:0] CDT_R_A = 3'h1;
	localparam logic [1:0] CDT_RP_AX = 2'h0;

	// Short direct addressing window
	localparam logic [15:0] CDT_SADDR_LO = 16'hFE20;
	localparam logic [15:0] CDT_SADDR_HI = 16'hFF1F;

	// Instruction lengths in CPU clocks
	localparam logic [3:0] CDT_CLK4 = 4'h4;
	localparam logic [3:0] CDT_CLK6 = 4'h6;
	localparam logic [3:0] CDT_CLK8 = 4'h8;

	// Values after reset
	localparam logic [7:0]  CDT_REG_RST  = 8'h00;
	localparam logic [7:0]  CDT_PSW_RST  = 8'h00;
	localparam logic [1:0]  CDT_PCC_RST  = 2'h0;
	localparam logic [15:0] CDT_PC_RST   = 16'h0000;
	localparam logic [7:0]  CDT_PORT_RST = 8'h00;
	localparam logic [7:0]  CDT_DIR_RST  = 8'h00;
	localparam logic [7:0]  CDT_SAVE_RST = 8'h00;

	// Operation codes of the command register
	typedef enum logic [3:0] {
		CDT_OP_MOV_R_IMM   = 4'h0,
		CDT_OP_MOV_A_R     = 4'h1,
		CDT_OP_MOV_R_A     = 4'h2,
		CDT_OP_MOV_PSW_IMM = 4'h3,
		CDT_OP_MOV_A_PSW   = 4'h4,
		CDT_OP_MOV_PSW_A   = 4'h5,
		CDT_OP_XCH_A_R     = 4'h6,
		CDT_OP_MOVW_RP_IMM = 4'h7,
		CDT_OP_MOVW_AX_RP  = 4'h8,
		CDT_OP_MOVW_RP_AX  = 4'h9,
		CDT_OP_XCHW        = 4'hA,
		CDT_OP_BR_REL      = 4'hB,
		CDT_OP_PSW_BIT     = 4'hC,
		CDT_OP_PSW_RESTORE = 4'hD,
		CDT_OP_ADDR_SADDR  = 4'hE,
		CDT_OP_ADDR_ABS    = 4'hF
	} cdt_op_t;

	// Sequencer states, Gray along idle, execute, commit
	typedef enum logic [1:0] {
		CDT_IDLE = 2'b00,
		CDT_EXEC = 2'b01,
		CDT_DONE = 2'b11
	} cdt_state_t;
endpackage

// ===== logic/cdt_rf_if.sv
// Carrier between the engine and its general register bank.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cdt_rf_if;
	logic [7:0]      we;
	logic [7:0][7:0] wd;
	logic [7:0][7:0] q;
	modport core (output we, output wd, input q);
	modport bank (input we, input wd, output q);
endinterface

// ===== logic/cdt_regbank.sv
// Eight byte registers X, A, C, B, E, D, L, H, indexed 0 to 7.
// Assumes the engine presents a whole next image with per-byte enables.
`timescale 1ns/1ps
module cdt_regbank (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Register access
	cdt_rf_if.bank    rf
);
	import cdt_pkg::*;

	// One flip-flop byte per register number
	for (genvar i = 0; i < 8; i++)
	begin : g_reg
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
				rf.q[i] <= CDT_REG_RST;
			else if (rf.we[i])
				rf.q[i] <= rf.wd[i];
		end
	end
endmodule

// ===== logic/cdt_core.sv
// Operand decoder and data transfer engine with an Avalon-MM slave.
// Assumes one 200 MHz clock; the strap pin is asynchronous.
// What this block does
// - Programming mode returns non-link pins to reset
// - Register field selects X A C B E D L H
// - Pair field selects AX, BC, DE, HL
// - Short direct only FE20H-FF1FH, words even
// - Absolute address full space, even for words
// - Immediates are 16, 8 and 3 bits wide
// - Branch adds signed 8-bit displacement to PC
// - Byte accumulator is implicit byte operand
// - Word accumulator pair is implicit word operand
// - Each pair reachable as high and low byte
// - Status word holds Z, AC, CY, IE, NMI_IN_PROGRESS_FLAG
// - Unmarked flags kept, forced or computed otherwise
// - Restored flags reload from the saved value
// - Accumulator moves refuse accumulator as register
// - Instruction clock is one divided CPU clock
`timescale 1ns/1ps
module cdt_core (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// Avalon-MM slave
	input  wire logic [cdt_pkg::CDT_AW-1:0]    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [cdt_pkg::CDT_DW-1:0]    avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic      [cdt_pkg::CDT_DW-1:0]    avs_readdata,
	output logic                               avs_waitrequest,
	// Programming mode strap, asynchronous
	input  wire logic                          prog_mode_pin,
	// General port pins
	output logic      [cdt_pkg::CDT_PORT_W-1:0] port_out,
	output logic      [cdt_pkg::CDT_PORT_W-1:0] port_oe_n
);
	import cdt_pkg::*;

	logic                 prog_s1_q;
	logic                 prog_s2_q;
	logic [CDT_DIV_W-1:0] div_q;
	logic [CDT_DIV_W-1:0] div_mask;
	logic                 cpu_en;
	logic [1:0]           pcc_q;
	logic                 rd_pend_q;
	logic [31:0]          readdata_q;
	logic [31:0]          rd_d;
	logic [31:0]          bemask;
	logic [31:0]          wmix;
	logic                 wr_acc;
	logic                 cmd_hit;
	logic                 busy;
	logic                 commit;
	cdt_state_t           state_q;
	logic [3:0]           cnt_q;
	logic [31:0]          cmd_q;
	cdt_op_t              op_c;
	logic [2:0]           r_c;
	logic [1:0]           rp_c;
	logic [15:0]          imm_c;
	logic [2:0]           hi_c;
	logic [2:0]           lo_c;
	logic [7:0]           psw_q;
	logic [7:0]           save_q;
	logic [15:0]          pc_q;
	logic [15:0]          addr_q;
	logic [7:0]           port_q;
	logic [7:0]           dir_q;
	logic                 err_op_q;
	logic                 err_ad_q;
	logic [7:0][7:0]      nx;
	logic                 reg_ld;
	logic [7:0]           psw_n;
	logic                 psw_ld;
	logic [15:0]          pc_n;
	logic                 pc_ld;
	logic                 addr_ld;
	logic                 bad_op;
	logic                 bad_ad;
	cdt_rf_if             rf ();

	// Length of each operation in CPU clocks
	function automatic logic [3:0] cdt_clocks(cdt_op_t op, logic w);
		case (op)
			CDT_OP_MOV_A_R,
			CDT_OP_MOV_R_A,
			CDT_OP_MOV_A_PSW,
			CDT_OP_MOV_PSW_A,
			CDT_OP_MOVW_AX_RP,
			CDT_OP_MOVW_RP_AX:
				return CDT_CLK4;
			CDT_OP_XCHW,
			CDT_OP_ADDR_ABS:
				return CDT_CLK8;
			CDT_OP_ADDR_SADDR:
				return w ? CDT_CLK6 : CDT_CLK4;
			default:
				return CDT_CLK6;
		endcase
	endfunction

	// Two-flop synchroniser for the strap; only stage two is read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prog_s1_q <= 1'b0;
			prog_s2_q <= 1'b0;
		end
		else
		begin
			prog_s1_q <= prog_mode_pin;
			prog_s2_q <= prog_s1_q;
		end
	end

	// CPU clock enable: one pulse every 2^pcc system clocks
	assign div_mask = CDT_DIV_W'((4'h1 << pcc_q) - 4'h1);
	assign cpu_en   = (div_q & div_mask) == '0;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	// Bus handshake: reads wait one cycle so data come from a flop
	assign busy            = state_q != CDT_IDLE;
	assign cmd_hit         = avs_address == CDT_OFF_CMD;
	assign avs_waitrequest = (avs_read & ~rd_pend_q)
	                       | (avs_write & cmd_hit & busy);
	assign wr_acc          = avs_write & ~avs_waitrequest;
	assign avs_readdata    = readdata_q;
	assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wmix   = avs_writedata & bemask;

	// Read data selection; unmapped offsets read zero
	always_comb
	begin
		rd_d = 32'h0000_0000;
		case (avs_address)
			CDT_OFF_CMD:  rd_d = cmd_q;
			CDT_OFF_STAT: rd_d = {28'h0, prog_s2_q, err_ad_q,
			                      err_op_q, busy};
			CDT_OFF_PSW:  rd_d = {24'h0, psw_q};
			CDT_OFF_PCC:  rd_d = {30'h0, pcc_q};
			CDT_OFF_PC:   rd_d = {16'h0, pc_q};
			CDT_OFF_RLO:  rd_d = rf.q[3:0];
			CDT_OFF_RHI:  rd_d = rf.q[7:4];
			CDT_OFF_ADDR: rd_d = {16'h0, addr_q};
			CDT_OFF_PORT: rd_d = {16'h0, dir_q, port_q};
			CDT_OFF_SAVE: rd_d = {24'h0, save_q};
			default:      rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_pend_q  <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end
		else
		begin
			rd_pend_q <= avs_read & ~rd_pend_q;
			if (avs_read & ~rd_pend_q)
				readdata_q <= rd_d;
		end
	end

	// Clock divide select written by software
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pcc_q <= CDT_PCC_RST;
		else if (wr_acc && avs_address == CDT_OFF_PCC)
			pcc_q <= (pcc_q & ~bemask[1:0]) | wmix[1:0];
	end

	// Saved status image used by restore
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			save_q <= CDT_SAVE_RST;
		else if (wr_acc && avs_address == CDT_OFF_SAVE)
			save_q <= (save_q & ~bemask[7:0]) | wmix[7:0];
	end

	// Port pins fall back to their reset state in programming mode
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			port_q <= CDT_PORT_RST;
			dir_q  <= CDT_DIR_RST;
		end
		else if (prog_s2_q)
		begin
			port_q <= CDT_PORT_RST;
			dir_q  <= CDT_DIR_RST;
		end
		else if (wr_acc && avs_address == CDT_OFF_PORT)
		begin
			port_q <= (port_q & ~bemask[7:0]) | wmix[7:0];
			dir_q  <= (dir_q & ~bemask[15:8]) | wmix[15:8];
		end
	end

	assign port_out  = port_q;
	assign port_oe_n = ~dir_q;

	// Command latch; waitrequest keeps it stable while busy
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cmd_q <= 32'h0000_0000;
		else if (wr_acc && cmd_hit)
			cmd_q <= (cmd_q & ~bemask) | wmix;
	end

	// Sequencer counts the instruction in CPU clock enables
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= CDT_IDLE;
			cnt_q   <= 4'h0;
		end
		else
		begin
			unique case (state_q)
				CDT_IDLE:
					if (wr_acc && cmd_hit)
					begin
						state_q <= CDT_EXEC;
						cnt_q   <= cdt_clocks(cdt_op_t'(
						           avs_writedata[CDT_CMD_OP +: 4]),
						           avs_writedata[CDT_CMD_R]);
					end
				CDT_EXEC:
					if (cpu_en)
					begin
						cnt_q <= cnt_q - 4'h1;
						if (cnt_q == 4'h1)
							state_q <= CDT_DONE;
					end
				CDT_DONE:
					state_q <= CDT_IDLE;
				default:
					state_q <= CDT_IDLE;
			endcase
		end
	end

	// Operand fields of the latched command
	assign commit = state_q == CDT_DONE;
	assign op_c   = cdt_op_t'(cmd_q[CDT_CMD_OP +: 4]);
	assign r_c    = cmd_q[CDT_CMD_R +: 3];
	assign rp_c   = cmd_q[CDT_CMD_RP +: 2];
	assign imm_c  = cmd_q[CDT_CMD_IMM +: 16];
	assign hi_c   = {rp_c, 1'b1};
	assign lo_c   = {rp_c, 1'b0};

	// Effect of each operation; refused register operands change nothing, refused addresses still load
	always_comb
	begin
		nx      = rf.q;
		reg_ld  = 1'b0;
		psw_n   = psw_q;
		psw_ld  = 1'b0;
		pc_n    = pc_q + {{8{imm_c[7]}}, imm_c[7:0]};
		pc_ld   = 1'b0;
		addr_ld = 1'b0;
		bad_op  = 1'b0;
		bad_ad  = 1'b0;
		unique case (op_c)
			CDT_OP_MOV_R_IMM:
			begin
				nx[r_c] = imm_c[7:0];
				reg_ld  = 1'b1;
			end
			CDT_OP_MOV_A_R:
				if (r_c == CDT_R_A)
					bad_op = 1'b1;
				else
				begin
					nx[CDT_R_A] = rf.q[r_c];
					reg_ld      = 1'b1;
				end
			CDT_OP_MOV_R_A:
				if (r_c == CDT_R_A)
					bad_op = 1'b1;
				else
				begin
					nx[r_c] = rf.q[CDT_R_A];
					reg_ld  = 1'b1;
				end
			CDT_OP_XCH_A_R:
				if (r_c == CDT_R_A || r_c == CDT_R_X)
					bad_op = 1'b1;
				else
				begin
					nx[CDT_R_A] = rf.q[r_c];
					nx[r_c]     = rf.q[CDT_R_A];
					reg_ld      = 1'b1;
				end
			CDT_OP_MOVW_RP_IMM:
			begin
				nx[hi_c] = imm_c[15:8];
				nx[lo_c] = imm_c[7:0];
				reg_ld   = 1'b1;
			end
			CDT_OP_MOVW_AX_RP:
				if (rp_c == CDT_RP_AX)
					bad_op = 1'b1;
				else
				begin
					nx[CDT_R_A] = rf.q[hi_c];
					nx[CDT_R_X] = rf.q[lo_c];
					reg_ld      = 1'b1;
				end
			CDT_OP_MOVW_RP_AX:
				if (rp_c == CDT_RP_AX)
					bad_op = 1'b1;
				else
				begin
					nx[hi_c] = rf.q[CDT_R_A];
					nx[lo_c] = rf.q[CDT_R_X];
					reg_ld   = 1'b1;
				end
			CDT_OP_XCHW:
				if (rp_c == CDT_RP_AX)
					bad_op = 1'b1;
				else
				begin
					nx[CDT_R_A] = rf.q[hi_c];
					nx[CDT_R_X] = rf.q[lo_c];
					nx[hi_c]    = rf.q[CDT_R_A];
					nx[lo_c]    = rf.q[CDT_R_X];
					reg_ld      = 1'b1;
				end
			CDT_OP_MOV_PSW_IMM:
			begin
				psw_n  = imm_c[7:0] & CDT_PSW_MASK;
				psw_ld = 1'b1;
			end
			CDT_OP_MOV_A_PSW:
			begin
				nx[CDT_R_A] = psw_q;
				reg_ld      = 1'b1;
			end
			CDT_OP_MOV_PSW_A:
			begin
				psw_n  = rf.q[CDT_R_A] & CDT_PSW_MASK;
				psw_ld = 1'b1;
			end
			CDT_OP_PSW_BIT:
			begin
				psw_n[imm_c[2:0]] = imm_c[3];
				psw_n  = psw_n & CDT_PSW_MASK;
				psw_ld = 1'b1;
			end
			CDT_OP_PSW_RESTORE:
			begin
				psw_n  = save_q & CDT_PSW_MASK;
				psw_ld = 1'b1;
			end
			CDT_OP_BR_REL:
				pc_ld = 1'b1;
			CDT_OP_ADDR_SADDR:
			begin
				addr_ld = 1'b1;
				bad_ad  = imm_c < CDT_SADDR_LO
				        || imm_c > CDT_SADDR_HI
				        || (r_c[0] && imm_c[0]);
			end
			CDT_OP_ADDR_ABS:
			begin
				addr_ld = 1'b1;
				bad_ad  = r_c[0] && imm_c[0];
			end
		endcase
	end

	// Register bank is written as a whole image at commit
	assign rf.we = {8{commit & reg_ld}};
	assign rf.wd = nx;

	cdt_regbank u_bank (
		.clk (clk),
		.rst (rst),
		.rf  (rf)
	);

	// Status word: only the PSW load, bit and restore operations move it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			psw_q <= CDT_PSW_RST;
		else if (commit && psw_ld)
			psw_q <= psw_n;
	end

	// Program counter; a committing branch wins over a bus write
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pc_q <= CDT_PC_RST;
		else if (commit && pc_ld)
			pc_q <= pc_n;
		else if (wr_acc && avs_address == CDT_OFF_PC)
			pc_q <= (pc_q & ~bemask[15:0]) | wmix[15:0];
	end

	// Last checked operand address, kept even when refused
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addr_q <= 16'h0000;
		else if (commit && addr_ld)
			addr_q <= imm_c;
	end

	// Sticky error flags, write one to clear; a new event wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			err_op_q <= 1'b0;
			err_ad_q <= 1'b0;
		end
		else
		begin
			if (commit && bad_op)
				err_op_q <= 1'b1;
			else if (wr_acc && avs_address == CDT_OFF_STAT
			         && wmix[CDT_ST_EOP])
				err_op_q <= 1'b0;
			if (commit && bad_ad)
				err_ad_q <= 1'b1;
			else if (wr_acc && avs_address == CDT_OFF_STAT
			         && wmix[CDT_ST_EAD])
				err_ad_q <= 1'b0;
		end
	end
endmodule

// ===== sim/cdt_core_sva.sv
// Port-level checker of the operand decoder and transfer engine.
// Assumes it is bound to cdt_core and sees only its ports.
`timescale 1ns/1ps
module cdt_core_sva (
	// Clock and reset
	input wire logic                          clk,
	input wire logic                          rst,
	// Register bus
	input wire logic [cdt_pkg::CDT_AW-1:0]    avs_address,
	input wire logic                          avs_read,
	input wire logic                          avs_write,
	input wire logic [cdt_pkg::CDT_DW-1:0]    avs_writedata,
	input wire logic [3:0]                    avs_byteenable,
	input wire logic [cdt_pkg::CDT_DW-1:0]    avs_readdata,
	input wire logic                          avs_waitrequest,
	// Strap and pins
	input wire logic                          prog_mode_pin,
	input wire logic [cdt_pkg::CDT_PORT_W-1:0] port_out,
	input wire logic [cdt_pkg::CDT_PORT_W-1:0] port_oe_n
);
	import cdt_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Building blocks of bus and strap behaviour
	sequence s_rd_go;
		avs_read && !$past(avs_read);
	endsequence
	sequence s_done;
		avs_read && !avs_waitrequest;
	endsequence
	sequence s_cmd_go;
		avs_write && avs_address == CDT_OFF_CMD && !avs_waitrequest;
	endsequence
	// Strap held long enough to pass the two-flop synchroniser
	sequence s_prog;
		prog_mode_pin[*4];
	endsequence

	property p_rd_wait;
		s_rd_go |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read did not answer after one wait state");
	property p_wr_fast;
		avs_write && avs_address != CDT_OFF_CMD |-> !avs_waitrequest;
	endproperty
	a_wr_fast: assert property (p_wr_fast)
		else $error("register write was stalled");
	property p_busy;
		s_cmd_go ##2 (avs_write && avs_address == CDT_OFF_CMD)
			|-> avs_waitrequest;
	endproperty
	a_busy: assert property (p_busy)
		else $error("command accepted while engine busy");
	property p_psw;
		s_done ##0 (avs_address == CDT_OFF_PSW)
			|-> (avs_readdata & ~{24'h0, CDT_PSW_MASK}) == 32'h0;
	endproperty
	a_psw: assert property (p_psw)
		else $error("status word shows bits outside its flags");
	property p_pcc;
		s_done ##0 (avs_address == CDT_OFF_PCC) |-> avs_readdata[31:2] == 0;
	endproperty
	a_pcc: assert property (p_pcc)
		else $error("clock control wider than two bits");
	property p_unmap;
		s_done ##0 (avs_address > CDT_OFF_SAVE) |-> avs_readdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read returned data");
	property p_prog;
		s_prog |=> port_out == 8'h00 && port_oe_n == 8'hFF;
	endproperty
	a_prog: assert property (p_prog)
		else $error("pins not at reset state in programming mode");
	property p_prog_stat;
		s_prog ##0 s_done ##0 (avs_address == CDT_OFF_STAT)
			|-> avs_readdata[CDT_ST_PROG];
	endproperty
	a_prog_stat: assert property (p_prog_stat)
		else $error("programming mode not shown in status");
endmodule

// ===== sim/tb.sv
// Self-checking bench of the operand decoder over its register bus.
// Assumes cdt_core with its checker bound; reads are scored in order.
`timescale 1ns/1ps
module tb;
	import cdt_pkg::*;
	typedef struct { string nm; logic [31:0] v; } cdt_exp_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        prog_mode_pin = 1'b0;
	logic [7:0]  port_out;
	logic [7:0]  port_oe_n;
	cdt_exp_t    q[$];
	cdt_exp_t    e;
	logic [7:0]  m[8];
	logic [31:0] rd;
	logic [15:0] w16;
	integer      seed = 34;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          w0;
	int          w1;
	logic [7:0]  offs[11] = '{CDT_OFF_CMD, CDT_OFF_STAT, CDT_OFF_PSW,
		CDT_OFF_PCC, CDT_OFF_PC, CDT_OFF_RLO, CDT_OFF_RHI, CDT_OFF_ADDR,
		CDT_OFF_PORT, CDT_OFF_SAVE, 8'h40};
	// Branch cases: start, displacement, target
	logic [39:0] br[3] = '{40'h0100800080, 40'h01007F017F,
		40'hFFF0200010};
	// Address cases: op, word, address, error
	logic [31:0] ad[9] = '{32'hE0FE2000, 32'hE0FE1F01, 32'hE0FF1F00,
		32'hE1FF1F01, 32'hE1FF1E00, 32'hE0FF2001, 32'hF1123501,
		32'hF0FFFF00, 32'hF1000000};

	always #2.5 clk = ~clk;

	cdt_core u_cdt_core (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.prog_mode_pin(prog_mode_pin), .port_out(port_out),
		.port_oe_n(port_oe_n));

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// One transfer, held until waitrequest is sampled low
	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
		output int w);
		@(posedge clk);
		avs_write <= wr;
		avs_read <= ~wr;
		avs_address <= a;
		avs_writedata <= d;
		w = 0;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
		begin
			w++;
			@(posedge clk);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		int w;
		bus(1'b1, a, d, w);
	endtask
	// Note the expectation one edge after the last transfer ends, so an
	// unscored poll finishing at that edge is never paired with it
	task automatic rx(logic [7:0] a, logic [31:0] v, string nm);
		int w;
		@(posedge clk);
		q.push_back('{nm, v});
		bus(1'b0, a, 32'h0, w);
	endtask
	// Poll status while the queue is empty, so polls are not scored
	task automatic op(logic [3:0] o, logic [2:0] r, logic [1:0] p,
		logic [15:0] i);
		int w;
		wr(CDT_OFF_CMD, {i, 6'h0, p, 1'b0, r, o});
		rd = 32'h1;
		while (rd[CDT_ST_BUSY] !== 1'b0)
			bus(1'b0, CDT_OFF_STAT, 32'h0, w);
	endtask
	task automatic regs();
		rx(CDT_OFF_RLO, {m[3], m[2], m[1], m[0]}, "rlo");
		rx(CDT_OFF_RHI, {m[7], m[6], m[5], m[4]}, "rhi");
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Score each completed read against the oldest note
	always @(posedge clk)
		if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0)
		begin
			e = q.pop_front();
			chk(e.nm, avs_readdata, e.v);
		end

	// Cut a hang short; the whole run needs about a thousand cycles
	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		close_out();
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (offs[k]) rx(offs[k], 32'h0, "reset");
		chk("oe_rst", {24'h0, port_oe_n}, 32'hFF);
		foreach (m[k])
		begin
			m[k] = 8'($random(seed));
			op(4'h0, 3'(k), 2'h0, {8'h0, m[k]});
		end
		regs();
		op(4'h1, CDT_R_A, 2'h0, 16'h0);
		op(4'h2, CDT_R_A, 2'h0, 16'h0);
		op(4'h6, CDT_R_X, 2'h0, 16'h0);
		rx(CDT_OFF_STAT, 32'h2, "refuse");
		wr(CDT_OFF_STAT, 32'h2);
		regs();
		op(4'h1, 3'h3, 2'h0, 16'h0);
		m[1] = m[3];
		op(4'h2, 3'h7, 2'h0, 16'h0);
		m[7] = m[1];
		op(4'h6, 3'h2, 2'h0, 16'h0);
		{m[1], m[2]} = {m[2], m[1]};
		regs();
		for (int p = 0; p < 4; p++)
		begin
			w16 = 16'($random(seed));
			op(4'h7, 3'h0, 2'(p), w16);
			{m[2*p+1], m[2*p]} = w16;
		end
		regs();
		op(4'h8, 3'h0, 2'h2, 16'h0);
		{m[1], m[0]} = {m[5], m[4]};
		op(4'h9, 3'h0, 2'h3, 16'h0);
		{m[7], m[6]} = {m[1], m[0]};
		op(4'hA, 3'h0, 2'h1, 16'h0);
		{m[1], m[0], m[3], m[2]} = {m[3], m[2], m[1], m[0]};
		op(4'h8, 3'h0, CDT_RP_AX, 16'h0);
		regs();
		rx(CDT_OFF_STAT, 32'h2, "rp0");
		op(4'h3, 3'h0, 2'h0, 16'h00FF);
		rx(CDT_OFF_PSW, 32'hD3, "psw_imm");
		op(4'hC, 3'h0, 2'h0, 16'h0006);
		rx(CDT_OFF_PSW, 32'h93, "bit_clr");
		op(4'h4, 3'h0, 2'h0, 16'h0);
		m[1] = 8'h93;
		regs();
		op(4'h0, CDT_R_A, 2'h0, 16'h005A);
		op(4'h5, 3'h0, 2'h0, 16'h0);
		rx(CDT_OFF_PSW, 32'h52, "psw_a");
		wr(CDT_OFF_SAVE, 32'hC1);
		op(4'hD, 3'h0, 2'h0, 16'h0);
		rx(CDT_OFF_PSW, 32'hC1, "restore");
		op(4'hC, 3'h0, 2'h0, 16'h000C);
		rx(CDT_OFF_PSW, 32'hD1, "bit_set");
		foreach (br[k])
		begin
			wr(CDT_OFF_PC, {16'h0, br[k][39:24]});
			op(4'hB, 3'h0, 2'h0, {8'h0, br[k][23:16]});
			rx(CDT_OFF_PC, {16'h0, br[k][15:0]}, "branch");
		end
		foreach (ad[k])
		begin
			wr(CDT_OFF_STAT, 32'h6);
			op(ad[k][31:28], {2'h0, ad[k][24]}, 2'h0, ad[k][23:8]);
			rx(CDT_OFF_STAT, {29'h0, ad[k][0], 2'h0}, "addr");
			rx(CDT_OFF_ADDR, {16'h0, ad[k][23:8]}, "aop");
		end
		wr(CDT_OFF_PORT, 32'h0000A55A);
		@(posedge clk);
		chk("pout", {24'h0, port_out}, 32'h5A);
		chk("poe", {24'h0, port_oe_n}, 32'h5A);
		prog_mode_pin <= 1'b1;
		repeat (5) @(posedge clk);
		chk("pout_pg", {24'h0, port_out}, 32'h0);
		chk("poe_pg", {24'h0, port_oe_n}, 32'hFF);
		rx(CDT_OFF_STAT, 32'h8, "prog");
		wr(CDT_OFF_PORT, 32'h0000A55A);
		rx(CDT_OFF_PORT, 32'h0, "port_pg");
		prog_mode_pin <= 1'b0;
		// Second command stalls for as long as the first one runs
		wr(CDT_OFF_CMD, 32'h00000031);
		bus(1'b1, CDT_OFF_CMD, 32'h00000031, w0);
		wr(CDT_OFF_PCC, 32'h1);
		wr(CDT_OFF_CMD, 32'h00000031);
		bus(1'b1, CDT_OFF_CMD, 32'h00000031, w1);
		chk("stall0", 32'(w0), 32'(CDT_CLK4));
		chk("stall", {31'h0, w1 > w0}, 32'h1);
		close_out();
	end
endmodule

bind cdt_core cdt_core_sva u_cdt_core_sva (.clk(clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .prog_mode_pin(prog_mode_pin),
	.port_out(port_out), .port_oe_n(port_oe_n));
